//--- rtl/twrba_top.sv
/*
  Byte access logic for the 16-bit timer registers: counter, two compare
  values and capture value, reached over an 8-bit CPU bus through one shared
  high-byte holding register.
  Assumes one-cycle bus strobes synchronous to ref_clk and a master that
  keeps the byte order; the counting and capture engines sit outside.
  While clk_en is low every strobe is ignored and all state holds.
*/
// Notes on behaviour
// - Each wide register is reached as two byte operations, low and high.
// - Exactly one 8-bit holding register buffers the upper half.
// - The holding register is shared by all wide registers on writes, but only by counter and capture on reads.
// - Only the low-byte access starts the full 16-bit transfer.
// - Low-byte write loads holding byte as upper, written byte as lower, one cycle.
// - Low-byte read returns low half and, except on compare words, captures upper half into holding register.
// - Compare register reads bypass the holding register entirely.
`timescale 1ns/1ps
`default_nettype none
module twrba_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // CPU byte bus
  input wire logic [twrba_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [twrba_pkg::BYTE_W-1:0] bus_wdata,
  output logic [twrba_pkg::BYTE_W-1:0] bus_rdata,
  output logic bus_rvalid,
  // Timer side updates
  input wire logic count_load,
  input wire logic [twrba_pkg::WORD_W-1:0] count_next,
  input wire logic capture_load,
  input wire logic [twrba_pkg::WORD_W-1:0] capture_in,
  // Register values towards the timer
  output logic [twrba_pkg::WORD_W-1:0] timer_count_value,
  output logic [twrba_pkg::WORD_W-1:0] compare_value_a,
  output logic [twrba_pkg::WORD_W-1:0] compare_value_b,
  output logic [twrba_pkg::WORD_W-1:0] capture_value
);
  typedef struct packed {
    logic [twrba_pkg::BYTE_W-1:0] hold;
    logic [twrba_pkg::BYTE_W-1:0] rdata;
    logic rvalid;
  } twrba_state_type;

  twrba_state_type s_q;
  twrba_state_type s_d;

  // Stored words, one per timer register
  logic [twrba_pkg::WORD_W-1:0] word_val [twrba_pkg::NUM_WORDS];
  logic [twrba_pkg::NUM_WORDS-1:0] cpu_we;
  logic [twrba_pkg::WORD_W-1:0] cpu_val;

  // Decoded bus operation
  logic [twrba_pkg::IDX_W-1:0] sel_idx;
  logic sel_low;
  logic sel_direct;
  logic [twrba_pkg::WORD_W-1:0] sel_word;
  logic op_wr;
  logic op_rd;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;
  logic rd_snapshot;

  // Word index of a byte address
  function automatic logic [twrba_pkg::IDX_W-1:0] addr_index(
    input logic [twrba_pkg::ADDR_W-1:0] a
  );
    logic [twrba_pkg::IDX_W-1:0] idx;
    idx = twrba_pkg::IDX_COUNT;
    unique case (a)
      twrba_pkg::ADDR_COUNT_LO, twrba_pkg::ADDR_COUNT_HI: idx = twrba_pkg::IDX_COUNT;
      twrba_pkg::ADDR_CMP_A_LO, twrba_pkg::ADDR_CMP_A_HI: idx = twrba_pkg::IDX_CMP_A;
      twrba_pkg::ADDR_CMP_B_LO, twrba_pkg::ADDR_CMP_B_HI: idx = twrba_pkg::IDX_CMP_B;
      twrba_pkg::ADDR_CAPT_LO, twrba_pkg::ADDR_CAPT_HI: idx = twrba_pkg::IDX_CAPT;
    endcase
    return idx;
  endfunction

  // True for the low-order byte address of a word
  function automatic logic addr_is_low(input logic [twrba_pkg::ADDR_W-1:0] a);
    return (a == twrba_pkg::ADDR_COUNT_LO) || (a == twrba_pkg::ADDR_CMP_A_LO) ||
           (a == twrba_pkg::ADDR_CMP_B_LO) || (a == twrba_pkg::ADDR_CAPT_LO);
  endfunction

  // Compare words are the only ones read without the holding register
  function automatic logic is_compare(input logic [twrba_pkg::IDX_W-1:0] idx);
    return (idx == twrba_pkg::IDX_CMP_A) || (idx == twrba_pkg::IDX_CMP_B);
  endfunction

  // One-hot word enable for a word index
  function automatic logic [twrba_pkg::NUM_WORDS-1:0] word_onehot(
    input logic [twrba_pkg::IDX_W-1:0] idx
  );
    logic [twrba_pkg::NUM_WORDS-1:0] oh;
    oh = '0;
    oh[idx] = 1'b1;
    return oh;
  endfunction

  // Upper or lower byte of a word
  function automatic logic [twrba_pkg::BYTE_W-1:0] word_byte(
    input logic [twrba_pkg::WORD_W-1:0] w,
    input logic upper
  );
    logic [twrba_pkg::BYTE_W-1:0] b;
    b = w[twrba_pkg::BYTE_W-1:0];
    if (upper) begin
      b = w[twrba_pkg::WORD_W-1:twrba_pkg::BYTE_W];
    end
    return b;
  endfunction

  assign sel_idx = addr_index(bus_addr);
  assign sel_low = addr_is_low(bus_addr);
  assign sel_direct = is_compare(sel_idx);
  assign sel_word = word_val[sel_idx];

  // A write and a read in one cycle: the write is served, the read dropped
  assign op_wr = bus_wr;
  assign op_rd = bus_rd && !bus_wr;
  assign wr_low = op_wr && sel_low;
  assign wr_high = op_wr && !sel_low;
  assign rd_low = op_rd && sel_low;
  assign rd_high = op_rd && !sel_low;
  // Compare words leave the holding byte untouched on a low read
  assign rd_snapshot = rd_low && !sel_direct;

  // Upper half comes from the holding byte, lower half from the bus
  assign cpu_val = {s_q.hold, bus_wdata};
  // Only the low byte commits a word, so a lone high write stays harmless
  assign cpu_we = wr_low ? word_onehot(sel_idx) : '0;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = op_rd;
    // One holding byte for every word; a stray access clobbers it
    if (wr_high) begin
      s_d.hold = bus_wdata;
    end
    if (rd_low) begin
      s_d.rdata = word_byte(sel_word, 1'b0);
    end
    // Upper half is caught in the same cycle as the low byte leaves
    if (rd_snapshot) begin
      s_d.hold = word_byte(sel_word, 1'b1);
    end
    if (rd_high) begin
      s_d.rdata = sel_direct ? word_byte(sel_word, 1'b1) : s_q.hold;
    end
  end

  // clk_en low freezes every byte, the holding one included
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.hold <= twrba_pkg::HOLD_RST;
      s_q.rdata <= twrba_pkg::RDATA_RST;
      s_q.rvalid <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Counter word: the timer reloads it, a CPU write in the same cycle wins
  twrba_word_reg u_word_count (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cpu_we(cpu_we[twrba_pkg::IDX_COUNT]),
    .cpu_val(cpu_val),
    .hw_we(count_load),
    .hw_val(count_next),
    .value(word_val[twrba_pkg::IDX_COUNT])
  );

  // Compare words: only software writes them, the timer side never loads
  twrba_word_reg u_word_cmp_a (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cpu_we(cpu_we[twrba_pkg::IDX_CMP_A]),
    .cpu_val(cpu_val),
    .hw_we(1'b0),
    .hw_val(twrba_pkg::WORD_RST),
    .value(word_val[twrba_pkg::IDX_CMP_A])
  );

  twrba_word_reg u_word_cmp_b (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cpu_we(cpu_we[twrba_pkg::IDX_CMP_B]),
    .cpu_val(cpu_val),
    .hw_we(1'b0),
    .hw_val(twrba_pkg::WORD_RST),
    .value(word_val[twrba_pkg::IDX_CMP_B])
  );

  // Capture word: loaded by the capture engine, also writable by software
  twrba_word_reg u_word_capt (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cpu_we(cpu_we[twrba_pkg::IDX_CAPT]),
    .cpu_val(cpu_val),
    .hw_we(capture_load),
    .hw_val(capture_in),
    .value(word_val[twrba_pkg::IDX_CAPT])
  );

  // Words reach the timer straight from their flip-flops
  assign bus_rdata = s_q.rdata;
  assign bus_rvalid = s_q.rvalid;
  assign timer_count_value = word_val[twrba_pkg::IDX_COUNT];
  assign compare_value_a = word_val[twrba_pkg::IDX_CMP_A];
  assign compare_value_b = word_val[twrba_pkg::IDX_CMP_B];
  assign capture_value = word_val[twrba_pkg::IDX_CAPT];
endmodule
`default_nettype wire

//--- inc/twrba_pkg.sv
/*
  Constants shared by the wide-register byte access logic: byte addresses,
  widths, word indices and reset values.
  Assumes an 8-bit CPU data bus and one system clock.
*/
package twrba_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_WORDS = 4;
  localparam int unsigned IDX_W = 2;

  // Byte addresses on the CPU bus
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CMP_A_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CMP_A_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMP_B_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMP_B_HI = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_CAPT_LO = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_CAPT_HI = 3'h7;

  // Word indices
  localparam logic [IDX_W-1:0] IDX_COUNT = 2'h0;
  localparam logic [IDX_W-1:0] IDX_CMP_A = 2'h1;
  localparam logic [IDX_W-1:0] IDX_CMP_B = 2'h2;
  localparam logic [IDX_W-1:0] IDX_CAPT = 2'h3;

  // Values after reset
  localparam logic [BYTE_W-1:0] HOLD_RST = 8'h00;
  localparam logic [BYTE_W-1:0] RDATA_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage

//--- rtl/twrba_word_reg.sv
/*
  One 16-bit timer register with a CPU load port and a timer-side load port.
  Assumes strobes are synchronous to ref_clk; the CPU load has priority.
*/
`timescale 1ns/1ps
`default_nettype none
module twrba_word_reg (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // CPU side load
  input wire logic cpu_we,
  input wire logic [twrba_pkg::WORD_W-1:0] cpu_val,
  // Timer side load
  input wire logic hw_we,
  input wire logic [twrba_pkg::WORD_W-1:0] hw_val,
  // Stored value
  output logic [twrba_pkg::WORD_W-1:0] value
);
  typedef struct packed {
    logic [twrba_pkg::WORD_W-1:0] word;
  } twrba_word_state_type;

  twrba_word_state_type s_q;
  twrba_word_state_type s_d;

  always_comb begin
    s_d = s_q;
    // Software intent beats a timer update landing in the same cycle
    if (cpu_we) begin
      s_d.word = cpu_val;
    end else if (hw_we) begin
      s_d.word = hw_val;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.word <= twrba_pkg::WORD_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign value = s_q.word;
endmodule
`default_nettype wire

//--- tb/twrba_top_sva.sv
/* Assertions on the byte bus and word outputs of the top.
   Bound from the bench; sees only the top's ports. */
`timescale 1ns/1ps
`default_nettype none
module twrba_top_sva (
  // Clock, reset and inputs
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [2:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic count_load,
  input wire logic capture_load,
  // Outputs
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic [15:0] timer_count_value,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] compare_value_b,
  input wire logic [15:0] capture_value
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic rd = clk_en && bus_rd && !bus_wr;
  wire logic wr = clk_en && bus_wr;
  wire logic [63:0] words = {timer_count_value, compare_value_a, compare_value_b, capture_value};
  sequence hi_wr; wr && bus_addr == 3'h1; endsequence
  sequence lo_wr; wr && bus_addr == 3'h0 && !count_load; endsequence
  sequence lo_rd; rd && bus_addr == 3'h0; endsequence
  sequence hi_rd; rd && bus_addr == 3'h1; endsequence
  read_answer_a: assert property (rd |=> bus_rvalid) else $error("no read answer");
  no_answer_a: assert property (clk_en && !rd |=> !bus_rvalid)
    else $error("stray read answer");
  word_load_a: assert property (hi_wr ##1 lo_wr |=> timer_count_value ==
    {$past(bus_wdata, 2), $past(bus_wdata)}) else $error("word load wrong");
  hold_only_a: assert property (wr && bus_addr[0] && !count_load && !capture_load
    |=> $stable(words)) else $error("high write changed a word");
  cmp_direct_a: assert property (rd && bus_addr == 3'h3
    |=> bus_rdata == $past(compare_value_a[15:8])) else $error("compare high read");
  cmp_low_a: assert property (rd && bus_addr == 3'h4
    |=> bus_rdata == $past(compare_value_b[7:0])) else $error("compare low read");
  lo_read_a: assert property (lo_rd |=> bus_rdata == $past(timer_count_value[7:0]))
    else $error("low read wrong");
  hold_snapshot_a: assert property (lo_rd ##1 hi_rd
    |=> bus_rdata == $past(timer_count_value[15:8], 2)) else $error("high byte not held");
  shared_hold_a: assert property (hi_wr ##1 (rd && bus_addr == 3'h6) ##1 lo_wr
    |=> timer_count_value[15:8] == $past(capture_value[15:8], 2)) else $error("hold not shared");
endmodule
`default_nettype wire

//--- tb/twrba_cpu_model.sv
/* CPU byte-bus master model with byte and word access tasks.
   Assumes callers enter each task at a falling edge of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module twrba_cpu_model (
  // Bus
  input wire logic ref_clk,
  output logic [2:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);
  initial begin
    {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
  end
  // Strobe stays up so a following op runs back to back
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    bus_wr = w;
    bus_rd = !w;
    bus_addr = a;
    bus_wdata = d;
    @(negedge ref_clk);
    q = bus_rdata;
  endtask
  task automatic idle;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = ~bus_wdata;
    @(negedge ref_clk);
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    logic [7:0] q;
    op(1'b1, a | 3'h1, v[15:8], q);
    op(1'b1, a, v[7:0], q);
    idle();
  endtask
  // No gap between the bytes, so nothing can disturb the hold byte
  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    op(1'b0, a, 8'h00, v[7:0]);
    op(1'b0, a | 3'h1, 8'h00, v[15:8]);
    idle();
  endtask
endmodule
`default_nettype wire

//--- tb/twrba_top_tb.sv
/* Self-checking bench for the byte access top.
   Assumes the checker and CPU model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module twrba_top_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b0;
  logic count_load = 1'b0;
  logic capture_load = 1'b0;
  logic [15:0] count_next = 16'h0000;
  logic [15:0] capture_in = 16'h0000;
  logic [2:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic bus_rvalid;
  logic [7:0] bus_wdata, bus_rdata, q;
  logic [15:0] cnt, cmpa, cmpb, capt, w;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #2 ref_clk = ~ref_clk;
  twrba_top u_twrba_top (.ref_clk, .reset_n, .clk_en, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .bus_rvalid, .count_load, .count_next, .capture_load,
    .capture_in, .timer_count_value(cnt), .compare_value_a(cmpa), .compare_value_b(cmpb),
    .capture_value(capt));
  twrba_cpu_model u_twrba_cpu_model (.ref_clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata);
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end
  task automatic t_count;
    check("cnt rst", cnt, 16'h0000);
    u_twrba_cpu_model.wr16(3'h0, 16'h01FF);
    check("cnt wr", cnt, 16'h01FF);
    u_twrba_cpu_model.rd16(3'h0, w);
    check("cnt rd", w, 16'h01FF);
  endtask
  task automatic t_cmp;
    u_twrba_cpu_model.wr16(3'h2, 16'hA5C3);
    u_twrba_cpu_model.wr16(3'h4, 16'h3C5A);
    check("cmpa", cmpa, 16'hA5C3);
    check("cmpb", cmpb, 16'h3C5A);
    u_twrba_cpu_model.op(1'b1, 3'h1, 8'h77, q);
    u_twrba_cpu_model.op(1'b0, 3'h3, 8'h00, q);
    check("cmpa hi", q, 16'h00A5);
    u_twrba_cpu_model.op(1'b0, 3'h2, 8'h00, q);
    check("cmpa lo", q, 16'h00C3);
    u_twrba_cpu_model.op(1'b0, 3'h4, 8'h00, q);
    check("cmpb lo", q, 16'h005A);
    u_twrba_cpu_model.op(1'b0, 3'h5, 8'h00, q);
    check("cmpb hi", q, 16'h003C);
    u_twrba_cpu_model.op(1'b0, 3'h1, 8'h00, q);
    check("hold rd", q, 16'h0077);
    u_twrba_cpu_model.idle();
    check("cnt kept", cnt, 16'h01FF);
  endtask
  task automatic t_shared;
    capture_in = 16'hBEEF;
    capture_load = 1'b1;
    @(negedge ref_clk);
    capture_load = 1'b0;
    u_twrba_cpu_model.op(1'b1, 3'h1, 8'h12, q);
    u_twrba_cpu_model.op(1'b0, 3'h6, 8'h00, q);
    check("capt lo", q, 16'h00EF);
    u_twrba_cpu_model.op(1'b1, 3'h0, 8'h34, q);
    u_twrba_cpu_model.idle();
    check("cnt shared", cnt, 16'hBE34);
    check("capt kept", capt, 16'hBEEF);
    u_twrba_cpu_model.rd16(3'h6, w);
    check("capt rd", w, 16'hBEEF);
  endtask
  task automatic t_reset;
    reset_n = 1'b0;
    @(negedge ref_clk);
    check("rst cnt", cnt, 16'h0000);
    check("rst cmpa", cmpa, 16'h0000);
    check("rst cmpb", cmpb, 16'h0000);
    check("rst capt", capt, 16'h0000);
    check("rst rdata", bus_rdata, 16'h0000);
    reset_n = 1'b1;
    u_twrba_cpu_model.op(1'b0, 3'h1, 8'h00, q);
    check("rst hold", q, 16'h0000);
    check("rvalid", bus_rvalid, 16'h0001);
    u_twrba_cpu_model.idle();
    check("rvalid end", bus_rvalid, 16'h0000);
  endtask
  task automatic t_load;
    count_next = 16'h1234;
    count_load = 1'b1;
    @(negedge ref_clk);
    count_load = 1'b0;
    clk_en = 1'b0;
    u_twrba_cpu_model.op(1'b1, 3'h0, 8'h55, q);
    u_twrba_cpu_model.idle();
    clk_en = 1'b1;
    check("frozen", cnt, 16'h1234);
    u_twrba_cpu_model.op(1'b0, 3'h1, 8'h00, q);
    check("hi first", q, 16'h00BE);
    u_twrba_cpu_model.rd16(3'h0, w);
    check("cnt load", w, 16'h1234);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    clk_en = 1'b1;
    t_count();
    t_cmp();
    t_shared();
    t_load();
    t_reset();
    test_done();
  end
endmodule
bind twrba_top twrba_top_sva u_twrba_top_sva (.ref_clk, .reset_n, .clk_en, .bus_addr,
  .bus_wr, .bus_rd, .bus_wdata, .count_load, .capture_load, .bus_rdata, .bus_rvalid,
  .timer_count_value, .compare_value_a, .compare_value_b, .capture_value);
`default_nettype wire
